//--- rtl/ddlt_top.v
// Serial read port that returns the double-rate latency query table byte by byte.
`timescale 1ns/1ps
`include "ddlt_defines.vh"
module ddlt_top (
  input wire clock,
  input wire reset_n,
  input wire link_sel_n,
  input wire link_clk,
  input wire link_din,
  output wire link_dout,
  output reg link_dout_oe
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;

  reg [1:0] sel_sync;
  reg [1:0] clk_sync;
  reg [1:0] din_sync;
  reg clk_prev;
  reg [1:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] offset;
  reg [7:0] out_shift;
  reg load_pending;
  wire [7:0] header_byte;
  wire [7:0] rel;
  wire [2:0] row;
  wire [2:0] col;
  reg [7:0] row_freq;
  reg [7:0] row_code;
  reg [7:0] fast_lat;
  reg [7:0] dual_lat;
  reg [7:0] quad_lat;
  reg [7:0] table_byte;
  wire sel_n;
  wire clk_rise;
  wire clk_fall;

  // Only the second stage of each synchroniser feeds logic, to keep metastability contained.
  assign sel_n = sel_sync[1];
  assign clk_rise = clk_sync[1] & ~clk_prev;
  assign clk_fall = ~clk_sync[1] & clk_prev;
  assign link_dout = out_shift[7];

  // Rows are eight bytes long, so the offset past the header splits into row and column.
  assign rel = offset - `DDLT_OFS_FIRST_ROW;
  assign row = rel[`DDLT_ROW_MSB:`DDLT_ROW_LSB];
  assign col = rel[`DDLT_COL_MSB:`DDLT_COL_LSB];

  ddlt_rom u_rom (
    .offset(offset),
    .data(header_byte)
  );

  // Rows beyond the fourth lie past the table and decode as erased bytes.
  always @*
  begin
    row_freq = `DDLT_BLANK;
    row_code = `DDLT_BLANK;
    fast_lat = `DDLT_BLANK;
    dual_lat = `DDLT_BLANK;
    quad_lat = `DDLT_BLANK;
    case (row)
      `DDLT_ROW_11:
      begin
        row_freq = `DDLT_FREQ_50;
        row_code = `DDLT_CODE_11;
        fast_lat = `DDLT_FAST_LAT_11;
        dual_lat = `DDLT_DUAL_LAT_11;
        quad_lat = `DDLT_QUAD_LAT_11;
      end
      `DDLT_ROW_00:
      begin
        row_freq = `DDLT_FREQ_66;
        row_code = `DDLT_CODE_00;
        fast_lat = `DDLT_FAST_LAT_00;
        dual_lat = `DDLT_DUAL_LAT_00;
        quad_lat = `DDLT_QUAD_LAT_00;
      end
      `DDLT_ROW_01:
      begin
        row_freq = `DDLT_FREQ_66;
        row_code = `DDLT_CODE_01;
        fast_lat = `DDLT_FAST_LAT_01;
        dual_lat = `DDLT_DUAL_LAT_01;
        quad_lat = `DDLT_QUAD_LAT_01;
      end
      `DDLT_ROW_10:
      begin
        row_freq = `DDLT_FREQ_66;
        row_code = `DDLT_CODE_10;
        fast_lat = `DDLT_FAST_LAT_10;
        dual_lat = `DDLT_DUAL_LAT_10;
        quad_lat = `DDLT_QUAD_LAT_10;
      end
      default: row_freq = `DDLT_BLANK;
    endcase
  end

  // Bytes past the parameter read as erased flash so a host never sees stale table data.
  always @*
  begin
    table_byte = `DDLT_BLANK;
    if (offset < `DDLT_OFS_FIRST_ROW)
      table_byte = header_byte;
    else if (offset <= `DDLT_OFS_LAST)
    begin
      case (col)
        `DDLT_COL_FREQ: table_byte = row_freq;
        `DDLT_COL_CODE: table_byte = row_code;
        `DDLT_COL_FAST_MODE: table_byte = `DDLT_MODE_NONE;
        `DDLT_COL_FAST_LAT: table_byte = fast_lat;
        `DDLT_COL_DUAL_MODE: table_byte = `DDLT_MODE_NONE;
        `DDLT_COL_DUAL_LAT: table_byte = dual_lat;
        `DDLT_COL_QUAD_MODE: table_byte = `DDLT_MODE_QUAD;
        `DDLT_COL_QUAD_LAT: table_byte = quad_lat;
        default: table_byte = `DDLT_BLANK;
      endcase
    end
  end

  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      sel_sync <= `DDLT_SYNC_DESEL;
      clk_sync <= 2'h0;
      din_sync <= 2'h0;
      clk_prev <= 1'b0;
    end
    else
    begin
      sel_sync <= {sel_sync[0], link_sel_n};
      clk_sync <= {clk_sync[0], link_clk};
      din_sync <= {din_sync[0], link_din};
      clk_prev <= clk_sync[1];
    end
  end

  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      offset <= 8'h00;
      out_shift <= 8'h00;
      load_pending <= 1'b0;
      link_dout_oe <= 1'b0;
    end
    else if (sel_n)
    begin
      // A deselect at any bit abandons the frame, so a partial byte is simply dropped.
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      load_pending <= 1'b0;
      link_dout_oe <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          state <= ST_ADDR;
          bit_cnt <= 3'h0;
        end
        ST_ADDR:
        begin
          if (clk_rise)
          begin
            offset <= {offset[6:0], din_sync[1]};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == `DDLT_BITS_LAST)
            begin
              state <= ST_DATA;
              load_pending <= 1'b1;
            end
          end
        end
        ST_DATA:
        begin
          // Bits change on falling edges so the host samples a settled bit on each rising edge.
          if (clk_fall)
          begin
            link_dout_oe <= 1'b1;
            load_pending <= 1'b0;
            if (load_pending)
              out_shift <= table_byte;
            else
              out_shift <= {out_shift[6:0], 1'b0};
          end
          if (clk_rise)
          begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == `DDLT_BITS_LAST)
            begin
              // Reads run on through the table so one frame can fetch every row.
              offset <= offset + 8'h01;
              load_pending <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- rtl/ddlt_defines.vh
// Constants for the double-rate read latency query table and its serial read port.
`ifndef DDLT_DEFINES_VH
`define DDLT_DEFINES_VH
`define DDLT_OFS_ID 8'h00
`define DDLT_OFS_LEN 8'h01
`define DDLT_OFS_ROWS 8'h02
`define DDLT_OFS_ROWLEN 8'h03
`define DDLT_OFS_HDR_F 8'h04
`define DDLT_OFS_HDR_C 8'h05
`define DDLT_OFS_FAST_3B 8'h06
`define DDLT_OFS_FAST_4B 8'h07
`define DDLT_OFS_DUAL_3B 8'h08
`define DDLT_OFS_DUAL_4B 8'h09
`define DDLT_OFS_QUAD_3B 8'h0a
`define DDLT_OFS_QUAD_4B 8'h0b
`define DDLT_OFS_FIRST_ROW 8'h0c
`define DDLT_OFS_LAST 8'h2b
`define DDLT_ID 8'h9a
`define DDLT_LEN 8'h2a
`define DDLT_ROWS 8'h05
`define DDLT_ROWLEN 8'h08
`define DDLT_HDR_F 8'h46
`define DDLT_HDR_C 8'h43
`define DDLT_FAST_3B 8'h0d
`define DDLT_FAST_4B 8'h0e
`define DDLT_DUAL_3B 8'hbd
`define DDLT_DUAL_4B 8'hbe
`define DDLT_QUAD_3B 8'hed
`define DDLT_QUAD_4B 8'hee
`define DDLT_FREQ_50 8'h32
`define DDLT_FREQ_66 8'h42
`define DDLT_CODE_11 8'h03
`define DDLT_CODE_00 8'h00
`define DDLT_CODE_01 8'h01
`define DDLT_CODE_10 8'h02
`define DDLT_MODE_NONE 8'h00
`define DDLT_MODE_QUAD 8'h01
`define DDLT_COL_FREQ 3'h0
`define DDLT_COL_CODE 3'h1
`define DDLT_COL_FAST_MODE 3'h2
`define DDLT_COL_FAST_LAT 3'h3
`define DDLT_COL_DUAL_MODE 3'h4
`define DDLT_COL_DUAL_LAT 3'h5
`define DDLT_COL_QUAD_MODE 3'h6
`define DDLT_COL_QUAD_LAT 3'h7
`define DDLT_ROW_11 3'h0
`define DDLT_ROW_00 3'h1
`define DDLT_ROW_01 3'h2
`define DDLT_ROW_10 3'h3
`define DDLT_SYNC_DESEL 2'h3
`define DDLT_ROW_MSB 3'h5
`define DDLT_ROW_LSB 3'h3
`define DDLT_COL_MSB 3'h2
`define DDLT_COL_LSB 3'h0
`define DDLT_FAST_LAT_11 8'h04
`define DDLT_DUAL_LAT_11 8'h04
`define DDLT_QUAD_LAT_11 8'h03
`define DDLT_FAST_LAT_00 8'h05
`define DDLT_DUAL_LAT_00 8'h06
`define DDLT_QUAD_LAT_00 8'h06
`define DDLT_FAST_LAT_01 8'h06
`define DDLT_DUAL_LAT_01 8'h07
`define DDLT_QUAD_LAT_01 8'h07
`define DDLT_FAST_LAT_10 8'h07
`define DDLT_DUAL_LAT_10 8'h08
`define DDLT_QUAD_LAT_10 8'h08
`define DDLT_BLANK 8'hff
`define DDLT_BITS_LAST 3'h7
`endif

//--- rtl/ddlt_rom.v
// Constant lookup of the header bytes of the double-rate latency table by relative byte offset.
`timescale 1ns/1ps
`include "ddlt_defines.vh"
module ddlt_rom (
  input wire [7:0] offset,
  output reg [7:0] data
);
  always @*
  begin
    case (offset)
      `DDLT_OFS_ID: data = `DDLT_ID;
      `DDLT_OFS_LEN: data = `DDLT_LEN;
      `DDLT_OFS_ROWS: data = `DDLT_ROWS;
      `DDLT_OFS_ROWLEN: data = `DDLT_ROWLEN;
      `DDLT_OFS_HDR_F: data = `DDLT_HDR_F;
      `DDLT_OFS_HDR_C: data = `DDLT_HDR_C;
      `DDLT_OFS_FAST_3B: data = `DDLT_FAST_3B;
      `DDLT_OFS_FAST_4B: data = `DDLT_FAST_4B;
      `DDLT_OFS_DUAL_3B: data = `DDLT_DUAL_3B;
      `DDLT_OFS_DUAL_4B: data = `DDLT_DUAL_4B;
      `DDLT_OFS_QUAD_3B: data = `DDLT_QUAD_3B;
      `DDLT_OFS_QUAD_4B: data = `DDLT_QUAD_4B;
      default: data = `DDLT_BLANK;
    endcase
  end
endmodule

//--- bench/ddlt_props.sv
// Concurrent checks on the serial read port of the latency table.
`timescale 1ns/1ps
module ddlt_props (
  input wire clock,
  input wire reset_n,
  input wire link_sel_n,
  input wire link_clk,
  input wire link_din,
  input wire link_dout,
  input wire link_dout_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // Bounds allow the three-clock synchroniser lag plus one spare clock.
  sequence sel_idle;
    link_sel_n [*4];
  endsequence
  idle_oe_a: assert property (sel_idle |-> !link_dout_oe) else $error("oe high when idle");
  idle_hold_a: assert property (link_sel_n && !link_dout_oe |=> !link_dout_oe) else $error("oe rose idle");
  addr_quiet_a: assert property (sel_idle ##1 !link_sel_n |-> !link_dout_oe [*8]) else $error("oe in address");
  oe_rise_a: assert property ($rose(link_dout_oe) |-> !$past(link_sel_n, 4)) else $error("oe rose unselected");
  rise_fall_a: assert property ($rose(link_dout_oe) |-> !$past(link_clk, 2)) else $error("oe rose off fall");
  bit_move_a: assert property (link_dout_oe && $changed(link_dout) |-> !$past(link_clk, 2)) else $error("bit late");
  bit_hold_a: assert property (link_clk && $past(link_clk, 3) && link_dout_oe |-> $stable(link_dout))
    else $error("bit unsteady");
  oe_fall_a: assert property ($fell(link_dout_oe) |-> $past(link_sel_n, 2)) else $error("oe fell in frame");
endmodule
bind ddlt_top ddlt_props u_props (
  .clock(clock),
  .reset_n(reset_n),
  .link_sel_n(link_sel_n),
  .link_clk(link_clk),
  .link_din(link_din),
  .link_dout(link_dout),
  .link_dout_oe(link_dout_oe)
);

//--- bench/ddlt_host.sv
// Behavioural serial host that reads the latency table in framed transfers.
`timescale 1ns/1ps
module ddlt_host (
  input wire clock,
  input wire link_dout,
  output reg link_sel_n = 1'b1,
  output reg link_clk = 1'b0,
  output reg link_din = 1'b0
);
  reg [7:0] rx [0:63];
  // Sends the offset, then clocks nbits in; a count short of whole bytes aborts.
  task xfer(input [7:0] ofs, input integer nbits);
    integer i;
    begin
      @(negedge clock);
      link_sel_n = 1'b0;
      for (i = 0; i < 8 + nbits; i = i + 1)
      begin
        link_din = i < 8 ? ofs[7 - i] : !link_din;
        repeat (4) @(negedge clock);
        if (i >= 8)
          rx[(i - 8) / 8] = {rx[(i - 8) / 8][6:0], link_dout};
        link_clk = 1'b1;
        repeat (4) @(negedge clock);
        link_clk = 1'b0;
      end
      repeat (4) @(negedge clock);
      link_sel_n = 1'b1;
      link_din = !link_din;
      repeat (8) @(negedge clock);
    end
  endtask
endmodule

//--- bench/ddlt_top_bench.sv
// Self-checking bench that reads the latency table through the host model.
`timescale 1ns/1ps
module ddlt_top_bench;
  reg clock = 1'b0;
  reg reset_n = 1'b0;
  wire link_sel_n, link_clk, link_din, link_dout, link_dout_oe;
  integer miscompares = 0;
  integer samples_checked = 0;
  localparam [95:0] HDR = 96'h9a2a050846430d0ebdbeedee;
  always #20 clock = !clock;
  ddlt_top u_dut (
    .clock(clock),
    .reset_n(reset_n),
    .link_sel_n(link_sel_n),
    .link_clk(link_clk),
    .link_din(link_din),
    .link_dout(link_dout),
    .link_dout_oe(link_dout_oe)
  );
  ddlt_host u_host (
    .clock(clock),
    .link_dout(link_dout),
    .link_sel_n(link_sel_n),
    .link_clk(link_clk),
    .link_din(link_din)
  );
  function [7:0] exp_byte(input [7:0] o);
    reg [7:0] d;
    begin
      d = o - 8'h0c;
      if (o < 8'h0c)
        exp_byte = HDR[95 - 8 * o -: 8];
      else if (o > 8'h2b)
        exp_byte = 8'hff;
      else
        case (d[2:0])
          3'h0: exp_byte = d[4:3] != 2'h0 ? 8'h42 : 8'h32;
          3'h1: exp_byte = {6'h00, d[4:3] + 2'h3};
          3'h3: exp_byte = d[4:3] != 2'h0 ? 8'h04 + d[4:3] : 8'h04;
          3'h5: exp_byte = d[4:3] != 2'h0 ? 8'h05 + d[4:3] : 8'h04;
          3'h6: exp_byte = 8'h01;
          3'h7: exp_byte = d[4:3] != 2'h0 ? 8'h05 + d[4:3] : 8'h03;
          default: exp_byte = 8'h00;
        endcase
    end
  endfunction
  task check_byte(input [7:0] o, input [7:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp_byte(o))
      begin
        $display("[FAIL] byte %h expected %h seen %h", o, exp_byte(o), got);
        miscompares = miscompares + 1;
      end
    end
  endtask
  task read_run(input [7:0] o, input integer n);
    integer i;
    begin
      u_host.xfer(o, 8 * n);
      for (i = 0; i < n; i = i + 1)
        check_byte(o + i, u_host.rx[i]);
      $display("read of %0d bytes at %h done", n, o);
    end
  endtask
  task test_header;
    read_run(8'h00, 12);
  endtask
  // Runs past the end so the next-parameter location must read blank.
  task test_rows;
    read_run(8'h0c, 34);
  endtask
  // A partial byte must not disturb the offset of the following frame.
  task test_abort;
    begin
      u_host.xfer(8'h24, 5);
      read_run(8'h14, 1);
    end
  endtask
  task summarize;
    begin
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    test_header;
    test_rows;
    test_abort;
    summarize;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares = miscompares + 1;
    summarize;
  end
endmodule
